// >>> rtl/plc_regs.svh
// register offsets, field positions and reset values of the pll divider and lock control block
// assumes a 32-bit apb slave with 8-bit byte addresses and one aligned word per register
`ifndef PLC_REGS_SVH
`define PLC_REGS_SVH

// byte offsets of the registers
`define PLC_OFF_CTRL      8'h00
`define PLC_OFF_BW        8'h04
`define PLC_OFF_NMUL      8'h08
`define PLC_OFF_VRANGE    8'h0c
`define PLC_OFF_RDIV      8'h10

// control register fields
`define PLC_CTRL_IE_BIT   7
`define PLC_CTRL_FLAG_BIT 6
`define PLC_CTRL_ON_BIT   5
`define PLC_CTRL_BCS_BIT  4
`define PLC_CTRL_P_LSB    2
`define PLC_CTRL_E_LSB    0

// bandwidth register fields
`define PLC_BW_AUTO_BIT   7
`define PLC_BW_LOCK_BIT   6
`define PLC_BW_TRK_BIT    5

// reset values
`define PLC_RST_ON        1'b1
`define PLC_RST_P         2'h0
`define PLC_RST_E         2'h0
`define PLC_RST_N         12'h040
`define PLC_RST_L         8'h40
`define PLC_RST_R         4'h1

// nominal vco step, khz, that scales l times two to the e
`define PLC_F_NOM_KHZ     125

`endif

// >>> rtl/plc_pkg.sv
// types shared by the pll divider and lock control block
// assumes the offsets and reset values come from plc_regs.svh
package plc_pkg;

  typedef logic [11:0] plc_nmul_t;   // feedback modulo factor
  typedef logic [7:0]  plc_lin_t;    // vco linear factor
  typedef logic [3:0]  plc_rdiv_t;   // reference modulo factor
  typedef logic [1:0]  plc_exp_t;    // power-of-two exponents

  // lock detector sequence
  typedef enum logic [1:0] {
    LD_OFF,
    LD_MEASURE,
    LD_JUDGE
  } plc_ld_e;

endpackage

// >>> rtl/plc_div_if.sv
// carrier between the control logic and one modulo divider
// assumes both ends sit on the system clock
`timescale 1ns/100ps
interface plc_div_if #(
  parameter int W = 12
);
  logic         en;        // run the divider, else hold at start
  logic         tick_in;   // one input event
  logic [W-1:0] modulus;   // division factor, zero acts as one
  logic         tick_out;  // one output event per modulus inputs

  modport ctl (output en, output tick_in, output modulus, input tick_out);
  modport div (input en, input tick_in, input modulus, output tick_out);
endinterface

// >>> rtl/plc_divider.sv
// modulo event divider used for the reference, prescale and feedback paths
// assumes tick_in is a one-cycle pulse on the system clock
`timescale 1ns/100ps
module plc_divider #(
  parameter int W = 12
) (
  input  wire logic i_clk_sys,
  input  wire logic i_srst,
  plc_div_if.div    dv
);

  logic [W-1:0] cnt_r;   // events seen in this period
  logic         tick_r;  // registered output event
  logic [W-1:0] last;    // terminal count

  // zero modulus behaves like one
  assign last = (dv.modulus == '0) ? '0 : dv.modulus - {{(W-1){1'b0}}, 1'b1};

  ////////////////////////////////////////////////////////////////////////////
  // count events, pulse on the terminal one; held at start while disabled
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst || !dv.en)
    begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
    end
    else
    begin
      tick_r <= 1'b0;
      if (dv.tick_in)
      begin
        if (cnt_r >= last)
        begin
          cnt_r  <= '0;
          tick_r <= 1'b1;
        end
        else
        begin
          cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  assign dv.tick_out = tick_r;

endmodule

// >>> rtl/plc_top.sv
// pll divider, phase detector, lock detector and mode control, apb register slave
// assumes reference and vco clocks arrive as pins from outside the system clock domain
//
// Contract
// - divide reference clock by modulo factor r
// - vco through 2^p prescaler then modulo n
// - prescale exponent selects 1, 2, 4, 8
// - feedback factor n is twelve bits wide
// - centre frequency is l times 2^e steps
// - phase detector pulses up or down
// - lock detector compares feedback and reference frequency
// - acquisition mode reads track bit zero
// - track bit one means tracking filter mode
// - auto bit lets detector switch filter mode
// - auto mode track bit read-only, from tolerance
// - auto mode lock bit read-only, from tolerance
// - auto mode lock toggle raises interrupt
// - manual mode track bit written by software
// - manual mode lock reads zero, no interrupt
// - zero r or n acts as one
// - zero l disables pll and base select
// - factors writable only while pll off
`timescale 1ns/100ps
`include "plc_regs.svh"
module plc_top
  import plc_pkg::*;
#(
  parameter int WIN_REFS    = 16,  // reference events per measurement window
  parameter int TRK_IN_TOL  = 2,   // error at or below which tracking starts
  parameter int TRK_OUT_TOL = 4,   // error above which acquisition resumes
  parameter int LCK_IN_TOL  = 1,   // error at or below which lock is declared
  parameter int LCK_OUT_TOL = 3    // error above which lock is lost
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_srst,
  input  wire logic        i_pll_ref_clock,
  input  wire logic        i_vco_clock,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  output logic             o_pump_up,
  output logic             o_pump_dn,
  output logic             o_track_mode,
  output logic             o_pll_enable,
  output logic      [7:0]  o_vco_linear,
  output logic      [1:0]  o_vco_exp,
  output logic             o_base_clock_select,
  output logic             o_lock_irq
);

  // window and thresholds at counter width
  localparam logic [7:0] WIN_L  = 8'(WIN_REFS);
  localparam logic [7:0] TIN_L  = 8'(TRK_IN_TOL);
  localparam logic [7:0] TOUT_L = 8'(TRK_OUT_TOL);
  localparam logic [7:0] LIN_L  = 8'(LCK_IN_TOL);
  localparam logic [7:0] LOUT_L = 8'(LCK_OUT_TOL);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic        ref_meta_r;      // first synchroniser stage, reference
  logic        ref_sync_r;      // second stage
  logic        ref_prev_r;      // edge history
  logic        vco_meta_r;      // first synchroniser stage, vco
  logic        vco_sync_r;      // second stage
  logic        vco_prev_r;      // edge history
  logic        ref_edge;        // rising edge of reference pin
  logic        vco_edge;        // rising edge of vco pin

  logic        on_r;            // pll on bit
  logic        bcs_r;           // base clock select
  logic        ie_r;            // lock irq enable
  logic        flag_r;          // sticky lock change flag
  plc_exp_t    p_r;             // prescale exponent
  plc_exp_t    e_r;             // vco range exponent
  plc_nmul_t   n_r;             // feedback factor
  plc_lin_t    l_r;             // vco linear factor
  plc_rdiv_t   r_r;             // reference factor
  logic        auto_r;          // automatic bandwidth
  logic        sw_trk_r;        // software track bit
  logic        active_r;        // pll running
  logic        irq_r;           // interrupt output
  logic        trk_out_r;       // filter mode to loop filter
  logic        up_r;            // phase detector up
  logic        dn_r;            // phase detector down

  plc_ld_e     ld_state_r;      // lock detector sequence
  logic [7:0]  ref_cnt_r;       // reference events in window
  logic [7:0]  fb_cnt_r;        // feedback events in window
  logic        det_trk_r;       // detector tracking decision
  logic        det_lock_r;      // detector lock decision
  logic        det_lock_d_r;    // lock history for toggle detect
  logic [7:0]  err;             // frequency error of the window

  logic [31:0] prdata_r;        // read data
  logic        pready_r;        // access phase ready
  logic        pslverr_r;       // unmapped access
  logic [31:0] rd_mux;          // decoded read value
  logic        miss;            // no register at address
  logic        hit_ctrl;        // address decodes
  logic        hit_bw;
  logic        hit_nmul;
  logic        hit_vr;
  logic        hit_rdiv;
  logic        wr_fire;         // write takes effect this edge
  logic        lnz;             // linear factor non-zero
  logic        ref_tick;        // divided reference event
  logic        fb_tick;         // feedback event
  logic        lock_rd;         // lock bit as read
  logic        trk_rd;          // track bit as read

  plc_div_if #(.W(4))  ref_if ();
  plc_div_if #(.W(4))  pre_if ();
  plc_div_if #(.W(12)) fb_if ();

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; only the second stage feeds the edge detectors
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      ref_meta_r <= 1'b0;
      ref_sync_r <= 1'b0;
      ref_prev_r <= 1'b0;
      vco_meta_r <= 1'b0;
      vco_sync_r <= 1'b0;
      vco_prev_r <= 1'b0;
    end
    else
    begin
      ref_meta_r <= i_pll_ref_clock;
      ref_sync_r <= ref_meta_r;
      ref_prev_r <= ref_sync_r;
      vco_meta_r <= i_vco_clock;
      vco_sync_r <= vco_meta_r;
      vco_prev_r <= vco_sync_r;
    end
  end

  // sampling limits the vco pin to below half the system clock
  assign ref_edge = ref_sync_r & ~ref_prev_r;
  assign vco_edge = vco_sync_r & ~vco_prev_r;
  assign lnz      = (l_r != 8'h00);

  ////////////////////////////////////////////////////////////////////////////
  // divider chain
  assign ref_if.en      = active_r;
  assign ref_if.tick_in = ref_edge;
  assign ref_if.modulus = r_r;
  assign ref_tick       = ref_if.tick_out;

  assign pre_if.en      = active_r;
  assign pre_if.tick_in = vco_edge;
  assign pre_if.modulus = 4'(4'h1 << p_r);

  assign fb_if.en       = active_r;
  assign fb_if.tick_in  = pre_if.tick_out;
  assign fb_if.modulus  = n_r;
  assign fb_tick        = fb_if.tick_out;

  plc_divider #(.W(4)) u_ref_div (
    .i_clk_sys (i_clk_sys),
    .i_srst    (i_srst),
    .dv        (ref_if)
  );

  plc_divider #(.W(4)) u_pre_div (
    .i_clk_sys (i_clk_sys),
    .i_srst    (i_srst),
    .dv        (pre_if)
  );

  plc_divider #(.W(12)) u_fb_div (
    .i_clk_sys (i_clk_sys),
    .i_srst    (i_srst),
    .dv        (fb_if)
  );

  ////////////////////////////////////////////////////////////////////////////
  // phase detector: pulse width is the gap between the two events
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst || !active_r)
    begin
      up_r <= 1'b0;
      dn_r <= 1'b0;
    end
    else if ((up_r | ref_tick) && (dn_r | fb_tick))
    begin
      up_r <= 1'b0;
      dn_r <= 1'b0;
    end
    else
    begin
      up_r <= up_r | ref_tick;
      dn_r <= dn_r | fb_tick;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // lock detector: feedback events counted over a window of reference events
  assign err = (fb_cnt_r >= WIN_L) ? (fb_cnt_r - WIN_L) : (WIN_L - fb_cnt_r);

  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst || !active_r)
    begin
      ld_state_r <= LD_OFF;
      ref_cnt_r  <= 8'h00;
      fb_cnt_r   <= 8'h00;
      det_trk_r  <= 1'b0;
      det_lock_r <= 1'b0;
    end
    else
    begin
      case (ld_state_r)
        LD_OFF:
        begin
          ld_state_r <= LD_MEASURE;
          ref_cnt_r  <= 8'h00;
          fb_cnt_r   <= 8'h00;
        end
        LD_MEASURE:
        begin
          if (ref_tick)
          begin
            ref_cnt_r <= ref_cnt_r + 8'h01;
            if (ref_cnt_r == WIN_L - 8'h01)
            begin
              ld_state_r <= LD_JUDGE;
            end
          end
          if (fb_tick && fb_cnt_r != 8'hff)
          begin
            fb_cnt_r <= fb_cnt_r + 8'h01;
          end
        end
        LD_JUDGE:
        begin
          // hysteresis keeps the decisions from chattering at the edge
          if (err <= TIN_L)
          begin
            det_trk_r <= 1'b1;
          end
          else if (err > TOUT_L)
          begin
            det_trk_r <= 1'b0;
          end
          if (err <= LIN_L)
          begin
            det_lock_r <= 1'b1;
          end
          else if (err > LOUT_L)
          begin
            det_lock_r <= 1'b0;
          end
          // events in this cycle open the next window
          ref_cnt_r  <= {7'h00, ref_tick};
          fb_cnt_r   <= {7'h00, fb_tick};
          ld_state_r <= LD_MEASURE;
        end
        default:
        begin
          ld_state_r <= LD_OFF;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb address decode and read mux
  assign lock_rd = det_lock_r & auto_r;
  assign trk_rd  = auto_r ? det_trk_r : sw_trk_r;

  always_comb
  begin
    hit_ctrl = 1'b0;
    hit_bw   = 1'b0;
    hit_nmul = 1'b0;
    hit_vr   = 1'b0;
    hit_rdiv = 1'b0;
    miss     = 1'b0;
    rd_mux   = 32'h0000_0000;
    if (i_paddr == `PLC_OFF_CTRL)
    begin
      hit_ctrl = 1'b1;
      rd_mux[`PLC_CTRL_IE_BIT]                 = ie_r;
      rd_mux[`PLC_CTRL_FLAG_BIT]               = flag_r;
      rd_mux[`PLC_CTRL_ON_BIT]                 = on_r;
      rd_mux[`PLC_CTRL_BCS_BIT]                = bcs_r;
      rd_mux[`PLC_CTRL_P_LSB+1:`PLC_CTRL_P_LSB] = p_r;
      rd_mux[`PLC_CTRL_E_LSB+1:`PLC_CTRL_E_LSB] = e_r;
    end
    else if (i_paddr == `PLC_OFF_BW)
    begin
      hit_bw = 1'b1;
      rd_mux[`PLC_BW_AUTO_BIT] = auto_r;
      rd_mux[`PLC_BW_LOCK_BIT] = lock_rd;
      rd_mux[`PLC_BW_TRK_BIT]  = trk_rd;
    end
    else if (i_paddr == `PLC_OFF_NMUL)
    begin
      hit_nmul     = 1'b1;
      rd_mux[11:0] = n_r;
    end
    else if (i_paddr == `PLC_OFF_VRANGE)
    begin
      hit_vr      = 1'b1;
      rd_mux[7:0] = l_r;
    end
    else if (i_paddr == `PLC_OFF_RDIV)
    begin
      hit_rdiv    = 1'b1;
      rd_mux[3:0] = r_r;
    end
    else
    begin
      miss = 1'b1;    // unmapped: error answer, reads zero
    end
  end

  assign wr_fire = i_psel & i_penable & i_pwrite & pready_r;

  ////////////////////////////////////////////////////////////////////////////
  // apb handshake: one wait-free access phase, data captured at setup
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end
    else
    begin
      pready_r <= i_psel & ~i_penable;
      if (i_psel && !i_penable)
      begin
        pslverr_r <= miss;
        prdata_r  <= i_pwrite ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register: on, select, enable and exponents
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      on_r  <= `PLC_RST_ON;
      bcs_r <= 1'b0;
      ie_r  <= 1'b0;
      p_r   <= `PLC_RST_P;
      e_r   <= `PLC_RST_E;
    end
    else
    begin
      if (wr_fire && hit_ctrl)
      begin
        // on may not change together with select; select holds on high
        if (!bcs_r && (i_pwdata[`PLC_CTRL_BCS_BIT] == bcs_r))
        begin
          on_r <= i_pwdata[`PLC_CTRL_ON_BIT];
        end
        bcs_r <= on_r & lnz & (i_pwdata[`PLC_CTRL_ON_BIT] ? i_pwdata[`PLC_CTRL_BCS_BIT] : bcs_r);
        ie_r  <= auto_r & i_pwdata[`PLC_CTRL_IE_BIT];
        if (!on_r)
        begin
          p_r <= i_pwdata[`PLC_CTRL_P_LSB+1:`PLC_CTRL_P_LSB];
          e_r <= i_pwdata[`PLC_CTRL_E_LSB+1:`PLC_CTRL_E_LSB];
        end
      end
      else
      begin
        if (!on_r || !lnz)
        begin
          bcs_r <= 1'b0;
        end
        if (!auto_r)
        begin
          ie_r <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // factor registers, frozen while the pll is on
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      n_r <= `PLC_RST_N;
      l_r <= `PLC_RST_L;
      r_r <= `PLC_RST_R;
    end
    else if (wr_fire && !on_r)
    begin
      if (hit_nmul)
      begin
        n_r <= i_pwdata[11:0];
      end
      if (hit_vr)
      begin
        l_r <= i_pwdata[7:0];
      end
      if (hit_rdiv)
      begin
        r_r <= i_pwdata[3:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bandwidth register: auto and software track bit
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      auto_r   <= 1'b0;
      sw_trk_r <= 1'b0;
    end
    else if (wr_fire && hit_bw)
    begin
      auto_r <= i_pwdata[`PLC_BW_AUTO_BIT];
      if (!auto_r)
      begin
        sw_trk_r <= i_pwdata[`PLC_BW_TRK_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // run state, filter mode and lock interrupt; a toggle beats a clear
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      active_r     <= 1'b0;
      trk_out_r    <= 1'b0;
      det_lock_d_r <= 1'b0;
      flag_r       <= 1'b0;
      irq_r        <= 1'b0;
    end
    else
    begin
      active_r     <= on_r & lnz;
      trk_out_r    <= active_r & (auto_r ? det_trk_r : sw_trk_r);
      det_lock_d_r <= det_lock_r;
      if (!auto_r)
      begin
        flag_r <= 1'b0;
      end
      else if (det_lock_r != det_lock_d_r)
      begin
        flag_r <= 1'b1;
      end
      else if (wr_fire && hit_ctrl && i_pwdata[`PLC_CTRL_FLAG_BIT])
      begin
        flag_r <= 1'b0;
      end
      irq_r <= flag_r & ie_r & auto_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all from flip-flops
  assign o_prdata            = prdata_r;
  assign o_pready            = pready_r;
  assign o_pslverr           = pslverr_r;
  assign o_pump_up           = up_r;
  assign o_pump_dn           = dn_r;
  assign o_track_mode        = trk_out_r;
  assign o_pll_enable        = active_r;
  assign o_vco_linear        = l_r;
  assign o_vco_exp           = e_r;
  assign o_base_clock_select = bcs_r;
  assign o_lock_irq          = irq_r;

endmodule

// >>> bench/plc_top_monitor.sv
// checker for the apb answer and pll outputs of plc_top
// assumes it is bound to plc_top and sees its ports only
`timescale 1ns/100ps
module plc_top_monitor
  import plc_pkg::*;
(
  input wire logic       i_clk_sys,
  input wire logic       i_srst,
  input wire logic       i_psel,
  input wire logic       i_penable,
  input wire logic       o_pready,
  input wire logic       o_pump_up,
  input wire logic       o_pump_dn,
  input wire logic       o_pll_enable,
  input wire logic [7:0] o_vco_linear,
  input wire logic [1:0] o_vco_exp,
  input wire logic       o_base_clock_select
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);
  ////////////////////////////////////////////////////////////////
  // apb steps: setup, then a one-cycle access
  sequence s_setup;
    i_psel && !i_penable;
  endsequence
  sequence s_access;
    i_psel && i_penable && o_pready;
  endsequence
  a_ready_after_setup: assert property (s_setup |=> s_access)
    else $error("no pready after setup");
  a_ready_one_cycle: assert property (o_pready |=> !o_pready)
    else $error("pready longer than one cycle");
  a_ready_in_access: assert property (o_pready |-> i_psel && i_penable)
    else $error("pready outside access");
  a_pumps_exclusive: assert property (!(o_pump_up && o_pump_dn))
    else $error("both pumps high");
  a_select_needs_l: assert property (o_base_clock_select |-> o_vco_linear != 8'h00)
    else $error("select with zero linear factor");
  a_select_keeps_on: assert property (o_base_clock_select |-> o_pll_enable)
    else $error("select while pll off");
  a_enable_needs_l: assert property (o_pll_enable |-> $past(o_vco_linear) != 8'h00)
    else $error("pll enabled with zero linear factor");
  a_factors_frozen: assert property (o_pll_enable |-> $stable(o_vco_linear) && $stable(o_vco_exp))
    else $error("factor changed while pll on");
endmodule

// >>> bench/test_pll_divider_lock_control.sv
// self-checking bench for plc_top: registers, factors, lock and modes
// assumes plc_regs.svh offsets; pins are made from the system clock
`timescale 1ns/100ps
`include "plc_regs.svh"
module test_pll_divider_lock_control;
  logic        clk      = 1'b0;
  logic        srst     = 1'b1;
  logic        ref_pin  = 1'b0;
  logic        vco_pin  = 1'b0;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [7:0]  paddr    = 8'h00;
  logic [31:0] pwdata   = 32'h0;
  logic [31:0] prdata, q;
  logic        pready, pslverr, up, dn, trk, pen, base_clock_select, irq, e;
  logic [7:0]  lin;
  logic [1:0]  vexp;
  int          n_errors = 0, n_checks = 0, vco_half = 2, rc = 0, vc = 0;
  always #5 clk = ~clk;
  // ref every 8 cycles, vco every vco_half: a slow vco breaks lock
  always @(posedge clk)
  begin
    rc <= (rc == 7) ? 0 : rc + 1;
    if (rc == 7) ref_pin <= ~ref_pin;
    vc <= (vc >= vco_half - 1) ? 0 : vc + 1;
    if (vc >= vco_half - 1) vco_pin <= ~vco_pin;
  end
  plc_top #(.WIN_REFS(8)) plc_top_inst (.i_clk_sys(clk), .i_srst(srst), .i_pll_ref_clock(ref_pin),
    .i_vco_clock(vco_pin), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_pump_up(up),
    .o_pump_dn(dn), .o_track_mode(trk), .o_pll_enable(pen), .o_vco_linear(lin), .o_vco_exp(vexp),
    .o_base_clock_select(base_clock_select), .o_lock_irq(irq));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_checks++;
    if (g !== x)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // no cycle count assumed: only the watchdog ends a stuck access
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, x, q);
  endtask
  // bounded wait for an irq level
  task automatic wait_irq(input logic v);
    int k;
    k = 0;
    while (irq !== v && k < 3000)
    begin
      @(posedge clk);
      k++;
    end
    chk("irq", {31'h0, v}, {31'h0, irq});
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd(`PLC_OFF_CTRL, 32'h20, "ctrl");
    rd(`PLC_OFF_NMUL, 32'h40, "nmul");
    rd(`PLC_OFF_RDIV, 32'h1, "rdiv");
    apb(1'b1, `PLC_OFF_VRANGE, 32'h11);
    rd(`PLC_OFF_VRANGE, 32'h40, "frozen l");
    rd(8'h14, 32'h0, "unmapped");
    chk("slverr", 32'h1, {31'h0, e});
  endtask
  task automatic t_program;
    apb(1'b1, `PLC_OFF_CTRL, 32'h0);
    apb(1'b1, `PLC_OFF_NMUL, 32'hffff);
    rd(`PLC_OFF_NMUL, 32'hfff, "nmul width");
    apb(1'b1, `PLC_OFF_VRANGE, 32'h0);
    apb(1'b1, `PLC_OFF_CTRL, 32'h2e);
    rd(`PLC_OFF_CTRL, 32'h2e, "ctrl p e");
    repeat (2) @(posedge clk);
    chk("enable l0", 32'h0, {31'h0, pen});
    chk("exp", 32'h2, {30'h0, vexp});
    apb(1'b1, `PLC_OFF_CTRL, 32'h0);
    apb(1'b1, `PLC_OFF_NMUL, 32'h4);
    apb(1'b1, `PLC_OFF_VRANGE, 32'h40);
    apb(1'b1, `PLC_OFF_CTRL, 32'h0);
    @(posedge clk);
    chk("exp off", 32'h0, {30'h0, vexp});
  endtask
  task automatic t_lock;
    apb(1'b1, `PLC_OFF_BW, 32'h80);
    apb(1'b1, `PLC_OFF_CTRL, 32'ha0);
    wait_irq(1'b1);
    rd(`PLC_OFF_BW, 32'he0, "bw locked");
    chk("track", 32'h1, {31'h0, trk});
    apb(1'b1, `PLC_OFF_CTRL, 32'he0);
    wait_irq(1'b0);
    apb(1'b1, `PLC_OFF_CTRL, 32'hb0);
    apb(1'b1, `PLC_OFF_CTRL, 32'h80);
    @(posedge clk);
    chk("select held", 32'h1, {31'h0, base_clock_select & pen});
    apb(1'b1, `PLC_OFF_CTRL, 32'ha0);
    vco_half <= 8;
    wait_irq(1'b1);
    // a straddling window may drop lock before track; let a full slow window pass
    repeat (300) @(posedge clk);
    rd(`PLC_OFF_BW, 32'h80, "bw lost");
  endtask
  task automatic t_manual;
    apb(1'b1, `PLC_OFF_BW, 32'h0);
    vco_half <= 2;
    repeat (2) @(posedge clk);
    chk("irq manual", 32'h0, {31'h0, irq});
    rd(`PLC_OFF_CTRL, 32'h20, "ctrl manual");
    // restart in manual mode with the track bit still clear
    apb(1'b1, `PLC_OFF_CTRL, 32'h0);
    apb(1'b1, `PLC_OFF_CTRL, 32'h20);
    repeat (300) @(posedge clk);
    apb(1'b1, `PLC_OFF_BW, 32'h20);
    rd(`PLC_OFF_BW, 32'h20, "bw manual");
    chk("track manual", 32'h1, {31'h0, trk});
    repeat (20) @(posedge clk);
    apb(1'b1, `PLC_OFF_CTRL, 32'h30);
    @(posedge clk);
    chk("select manual", 32'h1, {31'h0, base_clock_select});
    chk("irq quiet", 32'h0, {31'h0, irq});
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    #300000;
    n_errors++;
    conclude;
  end
  initial
  begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    t_reset;
    t_program;
    t_lock;
    t_manual;
    conclude;
  end
endmodule
bind plc_top plc_top_monitor plc_top_monitor_inst (.i_clk_sys, .i_srst, .i_psel, .i_penable, .o_pready,
  .o_pump_up, .o_pump_dn, .o_pll_enable, .o_vco_linear, .o_vco_exp, .o_base_clock_select);
